/* src/bie_top.sv */
// back-end interrupt enable set/clear registers with ahb-lite slave
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "bie_defines.svh"

module bie_top
  import bie_pkg::*;
#(
  parameter int ADDR_W = `BIE_ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] status_in,
  output logic core_irq,
  output logic evt_irq
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : gen_addr_w_check
    $error("bie_top: ADDR_W must be 4..32");
  end

  // reset release through two flops
  logic [1:0] rst_sync;
  logic rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync[1];

  // word address match within the decoded range
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] off);
    logic [31:0] amask;
    amask = 32'hFFFF_FFFF >> (32 - ADDR_W);
    reg_hit = ((addr & amask) >> `BIE_WORD_LSB) == ((off & amask) >> `BIE_WORD_LSB);
  endfunction : reg_hit

  bie_state_t st;
  bie_state_t next_st;
  logic accept;
  logic [31:0] masked;
  logic [31:0] new_evt;
  logic [31:0] wdata_valid;
  logic [31:0] rd_word;

  assign accept = hsel && htrans[1] && hready && st.rsp.hreadyout;
  assign masked = status_in & st.enable & `BIE_EN_VALID;
  assign new_evt = masked & ~st.prev_masked;
  assign wdata_valid = hwdata & `BIE_EN_VALID;

  always_comb begin
    rd_word = `BIE_RST_WORD;
    if (reg_hit(st.addr, `BIE_OFF_EN_SET)) begin
      rd_word = st.enable;
    end else if (reg_hit(st.addr, `BIE_OFF_EN_CLR)) begin
      rd_word = masked;
    end else if (reg_hit(st.addr, `BIE_OFF_EVT_STATUS)) begin
      rd_word = st.evt_status;
    end else if (reg_hit(st.addr, `BIE_OFF_EVT_MASK)) begin
      rd_word = st.evt_mask;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rsp.hresp = `BIE_HRESP_OKAY;
    next_st.prev_masked = masked;
    next_st.evt_status = st.evt_status | new_evt;
    case (st.phase)
      BIE_WR_DATA: begin
        // on set, clear and status only ones act and zeros leave bits alone; the mask takes the written word limited to the defined enable bits
        if (reg_hit(st.addr, `BIE_OFF_EN_SET)) begin
          next_st.enable = st.enable | wdata_valid;
        end else if (reg_hit(st.addr, `BIE_OFF_EN_CLR)) begin
          next_st.enable = st.enable & ~wdata_valid;
        end else if (reg_hit(st.addr, `BIE_OFF_EVT_STATUS)) begin
          // new event wins over the clear
          next_st.evt_status = (st.evt_status & ~wdata_valid) | new_evt;
        end else if (reg_hit(st.addr, `BIE_OFF_EVT_MASK)) begin
          next_st.evt_mask = wdata_valid;
        end
        next_st.phase = BIE_IDLE;
      end
      BIE_RD_WAIT: begin
        next_st.rsp.hrdata = rd_word;
        next_st.rsp.hreadyout = 1'b1;
        next_st.phase = BIE_RD_DONE;
      end
      BIE_RD_DONE: begin
        next_st.phase = BIE_IDLE;
      end
      BIE_IDLE: begin
        next_st.phase = BIE_IDLE;
      end
      default: begin
        next_st.phase = BIE_IDLE;
        next_st.rsp.hreadyout = 1'b1;
      end
    endcase
    if (accept) begin
      next_st.addr = haddr;
      if (hwrite) begin
        next_st.phase = BIE_WR_DATA;
        next_st.rsp.hreadyout = 1'b1;
      end else begin
        next_st.phase = BIE_RD_WAIT;
        next_st.rsp.hreadyout = 1'b0;
      end
    end
    next_st.core_irq = |(status_in & next_st.enable & `BIE_EN_VALID);
    next_st.evt_irq = |(next_st.evt_status & next_st.evt_mask);
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st.phase <= BIE_IDLE;
      st.addr <= `BIE_RST_WORD;
      st.rsp.hrdata <= `BIE_RST_WORD;
      st.rsp.hreadyout <= 1'b1;
      st.rsp.hresp <= `BIE_HRESP_OKAY;
      st.enable <= `BIE_RST_WORD;
      st.prev_masked <= `BIE_RST_WORD;
      st.evt_status <= `BIE_RST_WORD;
      st.evt_mask <= `BIE_RST_WORD;
      st.core_irq <= 1'b0;
      st.evt_irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rsp.hrdata;
  assign hreadyout = st.rsp.hreadyout;
  assign hresp = st.rsp.hresp;
  assign core_irq = st.core_irq;
  assign evt_irq = st.evt_irq;

endmodule : bie_top

/* pkg/bie_defines.svh */
// constants for the back-end interrupt enable set/clear block
`ifndef BIE_DEFINES_SVH
`define BIE_DEFINES_SVH

// register byte offsets
`define BIE_OFF_EN_SET 32'h0000_0000
`define BIE_OFF_EN_CLR 32'h0000_0004
`define BIE_OFF_EVT_STATUS 32'h0000_0008
`define BIE_OFF_EVT_MASK 32'h0000_000C

// enable field positions
`define BIE_BIT_HOST_TO_CORE 31
`define BIE_BIT_SOFT_HI 27
`define BIE_BIT_SOFT_LO 24
`define BIE_BIT_PARITY_ERR 6
`define BIE_BIT_SYSTEM_ERR 5
`define BIE_BIT_MASTER_ABORT 2
`define BIE_BIT_TARGET_ABORT 1

// defined enable bits: 31, 27:24, 6, 5, 2, 1
`define BIE_EN_VALID 32'h8F00_0066

// reset values
`define BIE_RST_WORD 32'h0000_0000

// default register address width
`define BIE_ADDR_W 12

// ahb codes
`define BIE_HRESP_OKAY 1'b0
`define BIE_WORD_LSB 2

`endif

/* pkg/bie_pkg.sv */
// types for the back-end interrupt enable set/clear block
package bie_pkg;

  typedef enum logic [1:0] {
    BIE_IDLE = 2'b00,
    BIE_WR_DATA = 2'b01,
    BIE_RD_WAIT = 2'b10,
    BIE_RD_DONE = 2'b11
  } bie_phase_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } bie_ahb_rsp_t;

  typedef struct packed {
    bie_phase_t phase;
    logic [31:0] addr;
    bie_ahb_rsp_t rsp;
    logic [31:0] enable;
    logic [31:0] prev_masked;
    logic [31:0] evt_status;
    logic [31:0] evt_mask;
    logic core_irq;
    logic evt_irq;
  } bie_state_t;

endpackage : bie_pkg

/* testbench/bie_monitor.sv */
// port assertions for the enable set/clear block
`timescale 1ns/100ps
module bie_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] status_in,
  input wire logic core_irq
);
  localparam logic [31:0] VAL = 32'h8F00_0066;
  wire logic take = hsel & htrans[1] & hready & hreadyout;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout) else $error("no read wait");
  wait_one_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write wait");
  rdata_load_a: assert property (!$stable(hrdata) |-> $rose(hreadyout)) else $error("hrdata moved");
  rsv_zero_a: assert property ((hrdata & ~VAL) == 32'h0000_0000) else $error("reserved bit set");
  irq_quiet_a: assert property ((status_in & VAL) == 32'h0000_0000 |=> !core_irq) else $error("stray irq");
  irq_cause_a: assert property (core_irq |-> ($past(status_in) & VAL) != 32'h0000_0000) else $error("no cause");
  cover property (take && hwrite);
  cover property (take && !hwrite);
  cover property ($rose(core_irq));
endmodule : bie_monitor

/* testbench/backend_irq_enable_set_clear_test.sv */
// self-checking bench for the enable set/clear block
`timescale 1ns/100ps
module backend_irq_enable_set_clear_test;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} bie_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, core_irq, evt_irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, status_in = 32'hFFFF_FFFF;
  int miscompares = 0, comparisons = 0;
  bie_row_t rows [16] = '{
    '{1'b0, 8'h00, 32'h0000_0000},
    '{1'b1, 8'h00, 32'hFFFF_FFFF},
    '{1'b0, 8'h00, 32'h8F00_0066},
    '{1'b0, 8'h04, 32'h8F00_0066},
    '{1'b0, 8'h08, 32'h8F00_0066},
    '{1'b1, 8'h04, 32'h0000_0004},
    '{1'b1, 8'h00, 32'h0000_0000},
    '{1'b0, 8'h00, 32'h8F00_0062},
    '{1'b1, 8'h04, 32'h8000_0000},
    '{1'b0, 8'h04, 32'h0F00_0062},
    '{1'b1, 8'h04, 32'h0000_0002},
    '{1'b1, 8'h00, 32'h0000_0002},
    '{1'b1, 8'h00, 32'h0000_0004},
    '{1'b0, 8'h00, 32'h0F00_0066},
    '{1'b0, 8'h10, 32'h0000_0000},
    '{1'b1, 8'h0C, 32'h0000_0002}
  };
  assign hready = hreadyout;
  always #20 core_clk = ~core_clk;
  bie_top uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .status_in(status_in), .core_irq(core_irq), .evt_irq(evt_irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    haddr <= 32'(a);
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask : xfer
  task wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(hrdata, rows[i].d);
    end
    repeat (4) @(posedge core_clk);
    chk(evt_irq, 1'b1);
    xfer(1'b1, 8'h08, 32'h0000_0002);
    repeat (4) @(posedge core_clk);
    chk(evt_irq, 1'b0);
    status_in <= 32'h0000_0000;
    repeat (4) @(posedge core_clk);
    chk(core_irq, 1'b0);
    status_in <= 32'h0000_0002;
    repeat (4) @(posedge core_clk);
    chk(core_irq, 1'b1);
    chk(evt_irq, 1'b1);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(hrdata, 32'h0000_0002);
    xfer(1'b1, 8'h04, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk(hrdata, 32'h0000_0000);
    repeat (4) @(posedge core_clk);
    chk(core_irq, 1'b0);
    xfer(1'b1, 8'h00, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk(hrdata, 32'h8F00_0066);
    chk(core_irq, 1'b1);
    rst_n <= 1'b0;
    @(posedge core_clk);
    chk(hrdata, 32'h0000_0000);
    chk(core_irq, 1'b0);
    chk(hreadyout, 1'b1);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk(hrdata, 32'h0000_0000);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(hrdata, 32'h0000_0000);
    chk(core_irq, 1'b0);
    wrap_up;
  end
endmodule : backend_irq_enable_set_clear_test
bind bie_top bie_monitor mon (.*);
